// *** dtmu_defs.svh ***
`ifndef DTMU_DEFS_SVH
`define DTMU_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices on the debug register port
// ----------------------------------------------------------------------------
`define DTMU_IDX_W 3
`define DTMU_IDX_CTRL 3'h0
`define DTMU_IDX_START0 3'h1
`define DTMU_IDX_START1 3'h2
`define DTMU_IDX_END0 3'h3
`define DTMU_IDX_END1 3'h4

// ----------------------------------------------------------------------------
// Channel control fields and reset values
// ----------------------------------------------------------------------------
`define DTMU_CH0_RW_HI 31
`define DTMU_CH1_RW_HI 29
`define DTMU_CH0_WATCH_BIT 0
`define DTMU_CH1_WATCH_BIT 1
`define DTMU_RW_READ_BIT 0
`define DTMU_RW_WRITE_BIT 1
`define DTMU_CTRL_RESET 32'h0000_0000
`define DTMU_ADDR_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// Message type codes and error reason
// ----------------------------------------------------------------------------
`define DTMU_TC_WRITE 6'h05
`define DTMU_TC_READ 6'h06
`define DTMU_TC_ERROR 6'h08
`define DTMU_TC_WRITE_SYNC 6'h0d
`define DTMU_TC_READ_SYNC 6'h0e
`define DTMU_TC_WATCH 6'h38
`define DTMU_TC_BITOP 6'h3a
`define DTMU_TC_BITOP_SYNC 6'h3b
`define DTMU_EC_OVERRUN 5'h02

// ----------------------------------------------------------------------------
// Periodic synchronisation count and message width
// ----------------------------------------------------------------------------
`define DTMU_PERIOD_MAX 8'hff
`define DTMU_MSG_W 90

`endif

// *** dtmu_pkg.sv ***
package dtmu_pkg;

	typedef enum logic [1:0] {
		DTMU_KIND_READ = 2'b00,
		DTMU_KIND_WRITE = 2'b01,
		DTMU_KIND_BITOP = 2'b10
	} dtmu_kind_e;

	typedef enum logic [1:0] {
		DTMU_ST_IDLE = 2'b00,
		DTMU_ST_DATA = 2'b01,
		DTMU_ST_WATCH = 2'b10
	} dtmu_state_e;

	typedef struct packed {
		logic [5:0] message_type_code;
		logic [4:0] error_reason_code;
		logic [31:0] data;
		logic [31:0] addr;
		logic [5:0] addr_len;
		logic [1:0] size;
		logic [4:0] bit_index;
		logic [1:0] bit_op;
	} dtmu_msg_s;

endpackage

// *** dtmu_buf.sv ***
`timescale 1ns/1ps
`include "dtmu_defs.svh"

module dtmu_buf (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [`DTMU_MSG_W-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [`DTMU_MSG_W-1:0] out_data
);

	logic [`DTMU_MSG_W-1:0] mem [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			if (push && !pop) begin
				count <= count + 2'h1;
			end else if (pop && !push) begin
				count <= count - 2'h1;
			end
		end
	end

endmodule

// *** dtmu.sv ***
`timescale 1ns/1ps
`include "dtmu_defs.svh"

// Summary of operation
// - Sync pending turns matching read into sync
// - Sync pending after reset
// - Sync pending when trace enabled while running
// - Sync pending on leaving power-down
// - Sync pending on event pin when selected
// - Overrun error message precedes next sync message
// - Force sync after 255 unsynchronised messages
// - First data message after leaving debug mode syncs
// - Read sync carries sized data and size
// - Sync carries full address, read code 14
// - Bit operation in active range gives 58
// - Bit operation: 5-bit index, 2-bit op
// - Unsynchronised address is only differing portion
// - Bit operation sync message code 59
// - Channel read/write enables at 31:30, 29:28
// - Watchpoint enables at control bits 0, 1
// - Each channel matches inclusive start..end range
// - Equal start and end match one address
// - Start above end never matches
// - Data messages only while trace mode set
// - Watchpoint hit sent as its own message

module dtmu (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Debug register port
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [`DTMU_IDX_W-1:0] REG_IDX,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	// Processor data access
	input wire logic ACC_VALID,
	input wire logic [1:0] ACC_KIND,
	input wire logic [31:0] ACC_ADDR,
	input wire logic [31:0] ACC_DATA,
	input wire logic [1:0] ACC_SIZE,
	input wire logic [4:0] ACC_BIT,
	input wire logic [1:0] ACC_BIT_OP,
	// Processor state and development control
	input wire logic TRACE_MODE,
	input wire logic CPU_RUN,
	input wire logic POWER_DOWN,
	input wire logic DEBUG_MODE,
	input wire logic EVENT_SYNC_SEL,
	input wire logic EVENT_INPUT_PIN,
	// Trace message output
	output logic MSG_VALID,
	input wire logic MSG_READY,
	output logic [5:0] MSG_TYPE_CODE,
	output logic [4:0] MSG_ERROR_REASON,
	output logic [31:0] MSG_DATA,
	output logic [31:0] MSG_ADDR,
	output logic [5:0] MSG_ADDR_LEN,
	output logic [1:0] MSG_SIZE,
	output logic [4:0] MSG_BIT,
	output logic [1:0] MSG_BIT_OP
);

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------

	// Number of significant bits, so leading zeros can be dropped.
	function automatic logic [5:0] sig_len(input logic [31:0] value);
		logic [5:0] len;
		len = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (value[i]) begin
				len = 6'(i + 1);
			end
		end
		return len;
	endfunction

	function automatic logic [31:0] size_mask(input logic [1:0] size);
		logic [31:0] mask;
		mask = 32'hffff_ffff;
		if (size == 2'h0) begin
			mask = 32'h0000_00ff;
		end else if (size == 2'h1) begin
			mask = 32'h0000_ffff;
		end
		return mask;
	endfunction

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------

	logic [31:0] channel_control;
	logic [31:0] range_start [0:1];
	logic [31:0] range_end [0:1];

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			channel_control <= `DTMU_CTRL_RESET;
			range_start[0] <= `DTMU_ADDR_RESET;
			range_start[1] <= `DTMU_ADDR_RESET;
			range_end[0] <= `DTMU_ADDR_RESET;
			range_end[1] <= `DTMU_ADDR_RESET;
		end else if (REG_WR) begin
			unique case (REG_IDX)
				`DTMU_IDX_CTRL: begin
					channel_control <= {REG_WDATA[31:28], 26'h0, REG_WDATA[1:0]};
				end
				`DTMU_IDX_START0: begin
					range_start[0] <= REG_WDATA;
				end
				`DTMU_IDX_START1: begin
					range_start[1] <= REG_WDATA;
				end
				`DTMU_IDX_END0: begin
					range_end[0] <= REG_WDATA;
				end
				`DTMU_IDX_END1: begin
					range_end[1] <= REG_WDATA;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h0000_0000;
		end else if (REG_RD) begin
			unique case (REG_IDX)
				`DTMU_IDX_CTRL: REG_RDATA <= channel_control;
				`DTMU_IDX_START0: REG_RDATA <= range_start[0];
				`DTMU_IDX_START1: REG_RDATA <= range_start[1];
				`DTMU_IDX_END0: REG_RDATA <= range_end[0];
				`DTMU_IDX_END1: REG_RDATA <= range_end[1];
				default: REG_RDATA <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Channel match
	// ------------------------------------------------------------------------

	logic [1:0] in_range;
	logic [1:0] trace_hit;
	logic [1:0] watch_en;
	logic [1:0] rw_en [0:1];

	assign rw_en[0] = channel_control[`DTMU_CH0_RW_HI -: 2];
	assign rw_en[1] = channel_control[`DTMU_CH1_RW_HI -: 2];
	assign watch_en[0] = channel_control[`DTMU_CH0_WATCH_BIT];
	assign watch_en[1] = channel_control[`DTMU_CH1_WATCH_BIT];

	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			// Inclusive range; equal bounds give one address, inverted bounds none.
			assign in_range[ch] = (range_start[ch] <= range_end[ch]) &&
				(ACC_ADDR >= range_start[ch]) && (ACC_ADDR <= range_end[ch]);
			always_comb begin
				unique case (ACC_KIND)
					dtmu_pkg::DTMU_KIND_READ: trace_hit[ch] = rw_en[ch][`DTMU_RW_READ_BIT];
					dtmu_pkg::DTMU_KIND_WRITE: trace_hit[ch] = rw_en[ch][`DTMU_RW_WRITE_BIT];
					dtmu_pkg::DTMU_KIND_BITOP: trace_hit[ch] = |rw_en[ch];
					default: trace_hit[ch] = 1'b0;
				endcase
			end
		end
	endgenerate

	logic data_fire;
	logic watch_fire;

	assign data_fire = ACC_VALID && TRACE_MODE && |(in_range & trace_hit);
	assign watch_fire = ACC_VALID && |(in_range & watch_en);

	// ------------------------------------------------------------------------
	// Synchronisation sources
	// ------------------------------------------------------------------------

	logic evt_s1;
	logic evt_s2;
	logic evt_q;
	logic trace_q;
	logic power_q;
	logic debug_q;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			evt_s1 <= 1'b0;
			evt_s2 <= 1'b0;
			evt_q <= 1'b0;
		end else begin
			evt_s1 <= EVENT_INPUT_PIN;
			evt_s2 <= evt_s1;
			evt_q <= evt_s2;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			trace_q <= 1'b0;
			power_q <= 1'b0;
			debug_q <= 1'b0;
		end else begin
			trace_q <= TRACE_MODE;
			power_q <= POWER_DOWN;
			debug_q <= DEBUG_MODE;
		end
	end

	logic sync_set;
	logic sync_pending;
	logic overrun;
	logic [7:0] period_cnt;
	logic need_sync;
	logic take;
	logic drop;
	dtmu_pkg::dtmu_state_e state;

	assign sync_set = (TRACE_MODE && !trace_q && CPU_RUN) ||
		(power_q && !POWER_DOWN) ||
		(debug_q && !DEBUG_MODE) ||
		(evt_s2 && !evt_q && EVENT_SYNC_SEL);
	assign need_sync = sync_pending || overrun || (period_cnt == `DTMU_PERIOD_MAX);

	logic buf_in_valid;
	logic buf_in_ready;
	logic [`DTMU_MSG_W-1:0] buf_in_data;

	assign take = (state == dtmu_pkg::DTMU_ST_IDLE) && buf_in_ready && (data_fire || watch_fire);
	assign drop = data_fire && !take;

	// Set wins over clear so an edge in the sending cycle is kept.
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sync_pending <= 1'b1;
		end else begin
			sync_pending <= sync_set || (sync_pending && !(take && data_fire));
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			overrun <= 1'b0;
		end else if (drop) begin
			overrun <= 1'b1;
		end else if (take && data_fire) begin
			overrun <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			period_cnt <= 8'h00;
		end else if (take && data_fire) begin
			if (need_sync) begin
				period_cnt <= 8'h00;
			end else begin
				period_cnt <= period_cnt + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Message composition
	// ------------------------------------------------------------------------

	logic [31:0] prev_addr;
	logic [31:0] uniq_addr;
	dtmu_pkg::dtmu_msg_s data_msg;
	dtmu_pkg::dtmu_msg_s err_msg;
	dtmu_pkg::dtmu_msg_s watch_msg;
	dtmu_pkg::dtmu_msg_s hold_data;
	dtmu_pkg::dtmu_msg_s hold_watch;
	logic watch_pending;

	assign uniq_addr = ACC_ADDR ^ prev_addr;

	always_comb begin
		data_msg = '0;
		data_msg.bit_index = ACC_BIT;
		data_msg.bit_op = ACC_BIT_OP;
		if (ACC_KIND != dtmu_pkg::DTMU_KIND_BITOP) begin
			data_msg.data = ACC_DATA & size_mask(ACC_SIZE);
			data_msg.size = ACC_SIZE;
			data_msg.bit_index = 5'h00;
			data_msg.bit_op = 2'h0;
		end
		if (need_sync) begin
			data_msg.addr = ACC_ADDR;
			data_msg.addr_len = sig_len(ACC_ADDR);
		end else begin
			data_msg.addr = uniq_addr;
			data_msg.addr_len = sig_len(uniq_addr);
		end
		unique case (ACC_KIND)
			dtmu_pkg::DTMU_KIND_WRITE: begin
				data_msg.message_type_code = need_sync ? `DTMU_TC_WRITE_SYNC : `DTMU_TC_WRITE;
			end
			dtmu_pkg::DTMU_KIND_BITOP: begin
				data_msg.message_type_code = need_sync ? `DTMU_TC_BITOP_SYNC : `DTMU_TC_BITOP;
			end
			default: begin
				data_msg.message_type_code = need_sync ? `DTMU_TC_READ_SYNC : `DTMU_TC_READ;
			end
		endcase
	end

	always_comb begin
		err_msg = '0;
		err_msg.message_type_code = `DTMU_TC_ERROR;
		err_msg.error_reason_code = `DTMU_EC_OVERRUN;
		watch_msg = '0;
		watch_msg.message_type_code = `DTMU_TC_WATCH;
		watch_msg.addr = ACC_ADDR;
		watch_msg.addr_len = sig_len(ACC_ADDR);
		watch_msg.bit_index = {3'h0, in_range & watch_en};
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			prev_addr <= 32'h0000_0000;
		end else if (take && data_fire) begin
			prev_addr <= ACC_ADDR;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			hold_data <= '0;
			hold_watch <= '0;
			watch_pending <= 1'b0;
		end else if (take) begin
			hold_data <= data_msg;
			hold_watch <= watch_msg;
			watch_pending <= watch_fire;
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer: error, data and watchpoint messages go out in that order
	// ------------------------------------------------------------------------

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state <= dtmu_pkg::DTMU_ST_IDLE;
		end else begin
			unique case (state)
				dtmu_pkg::DTMU_ST_IDLE: begin
					if (take && data_fire && overrun) begin
						state <= dtmu_pkg::DTMU_ST_DATA;
					end else if (take && data_fire && watch_fire) begin
						state <= dtmu_pkg::DTMU_ST_WATCH;
					end
				end
				dtmu_pkg::DTMU_ST_DATA: begin
					if (buf_in_ready) begin
						state <= watch_pending ? dtmu_pkg::DTMU_ST_WATCH : dtmu_pkg::DTMU_ST_IDLE;
					end
				end
				dtmu_pkg::DTMU_ST_WATCH: begin
					if (buf_in_ready) begin
						state <= dtmu_pkg::DTMU_ST_IDLE;
					end
				end
				default: begin
					state <= dtmu_pkg::DTMU_ST_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		buf_in_valid = 1'b0;
		buf_in_data = data_msg;
		unique case (state)
			dtmu_pkg::DTMU_ST_IDLE: begin
				buf_in_valid = take;
				if (data_fire && overrun) begin
					buf_in_data = err_msg;
				end else if (!data_fire) begin
					buf_in_data = watch_msg;
				end
			end
			dtmu_pkg::DTMU_ST_DATA: begin
				buf_in_valid = 1'b1;
				buf_in_data = hold_data;
			end
			dtmu_pkg::DTMU_ST_WATCH: begin
				buf_in_valid = 1'b1;
				buf_in_data = hold_watch;
			end
			default: begin
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Output buffer
	// ------------------------------------------------------------------------

	dtmu_pkg::dtmu_msg_s out_msg;
	logic [`DTMU_MSG_W-1:0] out_raw;

	dtmu_buf dtmu_buf_i (
		.clock(CLOCK),
		.rst_n(RST_N),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(MSG_VALID),
		.out_ready(MSG_READY),
		.out_data(out_raw)
	);

	assign out_msg = out_raw;
	assign MSG_TYPE_CODE = out_msg.message_type_code;
	assign MSG_ERROR_REASON = out_msg.error_reason_code;
	assign MSG_DATA = out_msg.data;
	assign MSG_ADDR = out_msg.addr;
	assign MSG_ADDR_LEN = out_msg.addr_len;
	assign MSG_SIZE = out_msg.size;
	assign MSG_BIT = out_msg.bit_index;
	assign MSG_BIT_OP = out_msg.bit_op;

endmodule

// *** dtmu_properties.sv ***
`timescale 1ns/1ps
`include "dtmu_defs.svh"

module dtmu_checker (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_N,
	// Register port
	input wire logic REG_RD,
	input wire logic [`DTMU_IDX_W-1:0] REG_IDX,
	input wire logic [31:0] REG_RDATA,
	// Access and message port
	input wire logic ACC_VALID,
	input wire logic MSG_VALID,
	input wire logic MSG_READY,
	input wire logic [5:0] MSG_TYPE_CODE,
	input wire logic [4:0] MSG_ERROR_REASON,
	input wire logic [31:0] MSG_DATA,
	input wire logic [31:0] MSG_ADDR,
	input wire logic [5:0] MSG_ADDR_LEN,
	input wire logic [1:0] MSG_SIZE,
	input wire logic [1:0] MSG_BIT_OP
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	logic data_msg;
	logic sync_msg;
	assign data_msg = MSG_VALID && MSG_TYPE_CODE inside {6'h05, 6'h06, 6'h0d, 6'h0e, 6'h3a, 6'h3b};
	assign sync_msg = MSG_VALID && MSG_TYPE_CODE inside {6'h0d, 6'h0e, 6'h3b};
	function automatic logic [5:0] top_len(input logic [31:0] x);
		top_len = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (x[i]) begin
				top_len = 6'(i + 1);
			end
		end
	endfunction
	ctrl_reserved_a: assert property (
		REG_RD && REG_IDX == 3'h0 |=> REG_RDATA[27:2] == 26'h0)
		else $error("reserved control bits read nonzero");
	message_type_code_legal_a: assert property (
		MSG_VALID |-> MSG_TYPE_CODE inside {6'h05, 6'h06, 6'h08, 6'h0d, 6'h0e, 6'h38, 6'h3a, 6'h3b})
		else $error("message type code outside the set in use");
	error_reason_a: assert property (
		MSG_VALID && MSG_TYPE_CODE == 6'h08 |-> MSG_ERROR_REASON inside {5'h02, 5'h07})
		else $error("error message with a wrong reason code");
	error_then_sync_a: assert property (
		MSG_VALID && MSG_READY && MSG_TYPE_CODE == 6'h08 |=> sync_msg)
		else $error("error message not followed by a sync message");
	addr_len_a: assert property (
		data_msg |-> MSG_ADDR_LEN == top_len(MSG_ADDR))
		else $error("address length does not drop leading zeros");
	size_data_a: assert property (
		data_msg && MSG_TYPE_CODE < 6'h3a |-> MSG_SIZE != 2'b11
		&& (MSG_SIZE == 2'b10 || MSG_DATA[31:16] == 16'h0)
		&& (MSG_SIZE != 2'b00 || MSG_DATA[15:8] == 8'h0))
		else $error("data value not sized to the access");
	bitop_type_a: assert property (
		data_msg && MSG_TYPE_CODE >= 6'h3a |-> MSG_BIT_OP != 2'b00)
		else $error("bit operation message with reserved type");
	msg_hold_a: assert property (
		MSG_VALID && !MSG_READY |=> MSG_VALID && $stable(MSG_TYPE_CODE) && $stable(MSG_ADDR))
		else $error("message changed before it was taken");
	valid_cause_a: assert property (
		$rose(MSG_VALID) |-> $past(ACC_VALID) || $past(ACC_VALID, 2) || $past(ACC_VALID, 3))
		else $error("message appeared without an access");
endmodule

bind dtmu dtmu_checker dtmu_checker_i (.CLOCK(CLOCK), .RST_N(RST_N), .REG_RD(REG_RD),
	.REG_IDX(REG_IDX), .REG_RDATA(REG_RDATA), .ACC_VALID(ACC_VALID), .MSG_VALID(MSG_VALID),
	.MSG_READY(MSG_READY), .MSG_TYPE_CODE(MSG_TYPE_CODE), .MSG_ERROR_REASON(MSG_ERROR_REASON),
	.MSG_DATA(MSG_DATA), .MSG_ADDR(MSG_ADDR), .MSG_ADDR_LEN(MSG_ADDR_LEN), .MSG_SIZE(MSG_SIZE),
	.MSG_BIT_OP(MSG_BIT_OP));

// *** dtmu_sink.sv ***
`timescale 1ns/1ps

module dtmu_sink (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Message handshake
	input wire logic stall,
	output logic msg_ready
);
	// The tool takes messages at once or after random waits, and never from the cycle after stall is sampled high.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			msg_ready <= 1'b0;
		end else begin
			msg_ready <= !stall && ($urandom % 3 != 0);
		end
	end
endmodule

// *** test_data_trace_message_unit.sv ***
`timescale 1ns/1ps
`include "dtmu_defs.svh"

module test_data_trace_message_unit;
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [2:0] REG_IDX = '0;
	logic [31:0] REG_WDATA = '0;
	logic [31:0] REG_RDATA;
	logic ACC_VALID = 1'b0;
	logic [1:0] ACC_KIND = '0;
	logic [31:0] ACC_ADDR = '0;
	logic [31:0] ACC_DATA = '0;
	logic [1:0] ACC_SIZE = '0;
	logic [4:0] ACC_BIT = '0;
	logic [1:0] ACC_BIT_OP = '0;
	logic TRACE_MODE = 1'b1;
	logic CPU_RUN = 1'b0;
	logic POWER_DOWN = 1'b0;
	logic DEBUG_MODE = 1'b0;
	logic EVENT_SYNC_SEL = 1'b0;
	logic EVENT_INPUT_PIN = 1'b0;
	logic MSG_VALID, MSG_READY;
	logic [5:0] MSG_TYPE_CODE, MSG_ADDR_LEN;
	logic [4:0] MSG_ERROR_REASON, MSG_BIT;
	logic [31:0] MSG_DATA, MSG_ADDR;
	logic [1:0] MSG_SIZE, MSG_BIT_OP;
	logic stall = 1'b0;
	int fails = 0;
	int num_checks = 0;
	int cnt = 0;
	logic pend = 1'b1;
	logic ovr = 1'b0;
	logic [31:0] prev_addr = '0;
	dtmu_pkg::dtmu_msg_s exp_q[$];
	dtmu_pkg::dtmu_msg_s seen, want;
	logic [32:0] tbl [6] = '{33'h0_0000_00ff, 33'h1_0000_0100, 33'h1_0000_01ff,
		33'h0_0000_0200, 33'h0_0000_02ff, 33'h0_0000_0300};
	logic [4:0] pulses [4] = '{5'b10001, 5'b01001, 5'b00100, 5'b00111};

	dtmu dtmu_i (.CLOCK(CLOCK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_IDX(REG_IDX), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ACC_VALID(ACC_VALID),
		.ACC_KIND(ACC_KIND), .ACC_ADDR(ACC_ADDR), .ACC_DATA(ACC_DATA), .ACC_SIZE(ACC_SIZE),
		.ACC_BIT(ACC_BIT), .ACC_BIT_OP(ACC_BIT_OP), .TRACE_MODE(TRACE_MODE), .CPU_RUN(CPU_RUN),
		.POWER_DOWN(POWER_DOWN), .DEBUG_MODE(DEBUG_MODE), .EVENT_SYNC_SEL(EVENT_SYNC_SEL),
		.EVENT_INPUT_PIN(EVENT_INPUT_PIN), .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY),
		.MSG_TYPE_CODE(MSG_TYPE_CODE), .MSG_ERROR_REASON(MSG_ERROR_REASON), .MSG_DATA(MSG_DATA),
		.MSG_ADDR(MSG_ADDR), .MSG_ADDR_LEN(MSG_ADDR_LEN), .MSG_SIZE(MSG_SIZE), .MSG_BIT(MSG_BIT),
		.MSG_BIT_OP(MSG_BIT_OP));
	dtmu_sink dtmu_sink_i (.clock(CLOCK), .rst_n(RST_N), .stall(stall), .msg_ready(MSG_READY));

	always #5 CLOCK = ~CLOCK;

	// ------
	// Checking
	// ------
	task automatic check(input string what, input logic [89:0] got, input logic [89:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic logic [5:0] len_of(input logic [31:0] x);
		len_of = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (x[i]) begin
				len_of = 6'(i + 1);
			end
		end
	endfunction
	always @(posedge CLOCK) begin
		if (RST_N && MSG_VALID && MSG_READY) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("mismatch extra expected none seen %h", MSG_TYPE_CODE);
			end else begin
				want = exp_q.pop_front();
				seen = '{MSG_TYPE_CODE, MSG_ERROR_REASON, MSG_DATA, MSG_ADDR, MSG_ADDR_LEN,
					MSG_SIZE, MSG_BIT, MSG_BIT_OP};
				check("msg", seen, want);
			end
		end
	end

	// ------
	// Stimulus
	// ------
	task automatic reg_wr(input logic [2:0] idx, input logic [31:0] d);
		@(posedge CLOCK);
		REG_WR <= 1'b1;
		REG_IDX <= idx;
		REG_WDATA <= d;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] idx, input logic [31:0] exp);
		@(posedge CLOCK);
		REG_RD <= 1'b1;
		REG_IDX <= idx;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		#1;
		check("reg", 90'(REG_RDATA), 90'(exp));
	endtask
	task automatic push(input logic [5:0] tc, input logic [31:0] d, input logic [31:0] a,
		input logic [5:0] len, input logic [1:0] sz, input logic [4:0] b, input logic [1:0] op);
		exp_q.push_back('{tc, (tc == 6'h08) ? 5'h02 : 5'h00, d, a, len, sz, b, op});
	endtask
	task automatic acc(input logic [1:0] k, input logic [31:0] a, input logic [1:0] sz,
		input logic hit);
		logic [31:0] d;
		logic [4:0] b;
		logic [1:0] op;
		logic sync;
		d = $urandom;
		b = 5'($urandom);
		op = 2'($urandom % 3 + 1);
		@(posedge CLOCK);
		ACC_VALID <= 1'b1;
		ACC_KIND <= k;
		ACC_ADDR <= a;
		ACC_DATA <= d;
		ACC_SIZE <= sz;
		ACC_BIT <= b;
		ACC_BIT_OP <= op;
		@(posedge CLOCK);
		ACC_VALID <= 1'b0;
		if (hit) begin
			sync = pend || ovr || cnt == 255;
			if (ovr) begin
				push(6'h08, 0, 0, 0, 0, 0, 0);
			end
			d = (sz == 2'b00) ? {24'h0, d[7:0]} : (sz == 2'b01) ? {16'h0, d[15:0]} : d;
			if (k == dtmu_pkg::DTMU_KIND_BITOP) begin
				d = 0;
				sz = 0;
				push(sync ? 6'h3b : 6'h3a, d, sync ? a : a ^ prev_addr,
					len_of(sync ? a : a ^ prev_addr), sz, b, op);
			end else begin
				push(6'(5 + (k == 2'b00) + (sync ? 8 : 0)), d, sync ? a : a ^ prev_addr,
					len_of(sync ? a : a ^ prev_addr), sz, 0, 0);
			end
			prev_addr = a;
			cnt = sync ? 0 : cnt + 1;
			pend = 1'b0;
			ovr = 1'b0;
		end
	endtask
	task automatic drain();
		for (int i = 0; i < 300 && exp_q.size() > 0; i++) begin
			@(posedge CLOCK);
		end
		if (exp_q.size() > 0) begin
			fails++;
			finish_test();
		end
		repeat (3) @(posedge CLOCK);
	endtask

	initial begin
		void'($urandom(32'h80b4fe54));
		repeat (20) @(posedge CLOCK);
		RST_N <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			reg_rd(3'(i), 32'h0);
		end
		reg_wr(3'h0, 32'hffff_ffff);
		reg_rd(3'h0, 32'hf000_0003);
		reg_wr(3'h0, 32'hf000_0000);
		reg_wr(3'h1, 32'h100);
		reg_wr(3'h3, 32'h1ff);
		reg_wr(3'h2, 32'h300);
		reg_wr(3'h4, 32'h2ff);
		reg_rd(3'h3, 32'h1ff);
		acc(2'b00, 32'h104, 2'b00, 1'b1);
		drain();
		for (int i = 0; i < 6; i++) begin
			acc(2'($urandom % 3), tbl[i][31:0], 2'($urandom % 3), tbl[i][32]);
			drain();
		end
		TRACE_MODE <= 1'b0;
		acc(2'b00, 32'h180, 2'b10, 1'b0);
		drain();
		CPU_RUN <= 1'b1;
		TRACE_MODE <= 1'b1;
		repeat (4) @(posedge CLOCK);
		pend = 1'b1;
		acc(2'b01, 32'h120, 2'b01, 1'b1);
		drain();
		for (int i = 0; i < 4; i++) begin
			EVENT_SYNC_SEL <= pulses[i][1];
			{POWER_DOWN, DEBUG_MODE, EVENT_INPUT_PIN} <= pulses[i][4:2];
			repeat (3) @(posedge CLOCK);
			{POWER_DOWN, DEBUG_MODE, EVENT_INPUT_PIN} <= 3'b000;
			repeat (6) @(posedge CLOCK);
			pend = pulses[i][0];
			acc(2'($urandom % 3), 32'h100 + 32'($urandom % 256), 2'b10, 1'b1);
			drain();
		end
		for (int i = 0; i < 256; i++) begin
			acc(2'b00, 32'h100 + 32'($urandom % 256), 2'($urandom % 3), 1'b1);
			drain();
		end
		stall <= 1'b1;
		repeat (3) @(posedge CLOCK);
		acc(2'b00, 32'h140, 2'b10, 1'b1);
		acc(2'b01, 32'h144, 2'b10, 1'b1);
		acc(2'b00, 32'h148, 2'b10, 1'b0);
		ovr = 1'b1;
		pend = 1'b1;
		stall <= 1'b0;
		drain();
		acc(2'b10, 32'h150, 2'b00, 1'b1);
		drain();
		reg_wr(3'h0, 32'hd000_0003);
		reg_wr(3'h2, 32'h400);
		reg_wr(3'h4, 32'h400);
		acc(2'b01, 32'h1ff, 2'b10, 1'b1);
		push(6'h38, 0, 32'h1ff, 6'h09, 0, 5'h01, 0);
		// A full buffer would drop the next watch-only hit, so let it empty first.
		drain();
		acc(2'b01, 32'h400, 2'b10, 1'b0);
		push(6'h38, 0, 32'h400, 6'h0b, 0, 5'h02, 0);
		drain();
		acc(2'b00, 32'h400, 2'b10, 1'b1);
		push(6'h38, 0, 32'h400, 6'h0b, 0, 5'h02, 0);
		drain();
		acc(2'b00, 32'h401, 2'b10, 1'b0);
		drain();
		finish_test();
	end
endmodule
